// ==== hw/scb_params.svh ====
`ifndef SCB_PARAMS_SVH
`define SCB_PARAMS_SVH

// register offsets inside one locality window
`define SCB_OFF_ACCESS   12'h000
`define SCB_OFF_CAP      12'h014
`define SCB_OFF_STATUS   12'h018
`define SCB_OFF_RESULT   12'h01C
`define SCB_LOC_MAX      3'h4
`define SCB_LOC_PRIV     3'h3

// field positions
`define SCB_BIT_LAUNCH   0
`define SCB_BIT_FIXSEL   8
`define SCB_BIT_CLRSTB   25
`define SCB_BIT_ABORT    24
`define SCB_ALW_HI       23
`define SCB_ALW_LO       8
`define SCB_BIT_ACCRDY   6
`define SCB_BIT_EXEC     5
`define SCB_BIT_RESP     4
`define SCB_BIT_ABORTED  0

// reset values and sizes
`define SCB_LAUNCH_RST   1'b1
`define SCB_FIXSEL_RST   1'b0
`define SCB_FIFO_BYTES   16'h0040
`define SCB_FIXED_BURST  16'h0020

// timing: clock rate, flag operation length, deadlines
`define SCB_CLK_MHZ      25
`define SCB_FLAGOP_CYC   16'h0008
`define SCB_SHORT_US     100
`define SCB_SHORT_CYC    (`SCB_SHORT_US * `SCB_CLK_MHZ)
`define SCB_LONG_US      1000
`define SCB_LONG_CYC     (`SCB_LONG_US * `SCB_CLK_MHZ)

`endif

// ==== hw/scb_pkg.sv ====
package scb_pkg;

    // command life cycle, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_READY = 6'h02,
        ST_RECV  = 6'h04,
        ST_EXEC  = 6'h08,
        ST_DONE  = 6'h10,
        ST_FLAG  = 6'h20
    } scb_state_t;

    // which direction the data FIFO serves
    typedef enum logic [2:0] {
        PH_NONE = 3'h1,
        PH_CMD  = 3'h2,
        PH_RESP = 3'h4
    } scb_phase_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } scb_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } scb_apb_rsp_t;

    // byte events of the data FIFO and firmware
    typedef struct packed {
        logic hostWrByte;
        logic hostRdByte;
        logic hostAllRead;
        logic fwDrainByte;
        logic fwFillByte;
        logic fwCmdDone;
        logic fwCanceled;
    } scb_fifo_ev_t;

    typedef struct packed {
        logic [15:0] count;
    } scb_tmr_t;

    typedef struct packed {
        logic [15:0] level;
        logic [15:0] burstLeft;
        logic        burstOpen;
    } scb_alw_t;

    typedef struct packed {
        scb_state_t  state;
        scb_phase_t  lastPhase;
        logic        launch;
        logic        respPending;
        logic        abortReq;
        logic        aborted;
        logic        fixedSel;
        logic [31:0] rdata;
        logic        err;
    } scb_core_t;

endpackage

// ==== hw/scb_cycle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module scb_cycle_timer (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        run,
    input  wire logic [15:0] limit,
    output logic             expired
);
    import scb_pkg::*;

    scb_tmr_t st;
    scb_tmr_t next_st;

    // expires in the limit-th cycle of run (count reaches limit - 1), holds while run
    assign expired = run && (st.count >= (limit - 16'h0001));

    // counts while running, restarts when run falls
    always_comb begin
        next_st = st;
        if (!run) begin
            next_st.count = 16'h0000;
        end else if (!expired) begin
            next_st.count = st.count + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    run_expires_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (run && st.count == 16'h0000 && limit == 16'h0008) ##1
        run [*7] |-> expired)
        else $error("timer did not expire after its limit");
endmodule // scb_cycle_timer
`default_nettype wire

// ==== hw/scb_allowance.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scb_params.svh"
module scb_allowance (
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    input  wire scb_pkg::scb_phase_t phase,
    input  wire logic               phaseStart,
    input  wire logic               fixedSel,
    input  wire logic               hostByte,
    input  wire logic               fwByte,
    output logic [15:0]             allowance
);
    import scb_pkg::*;

    scb_alw_t st;
    scb_alw_t next_st;

    // level in dynamic mode; in fixed mode zero during a burst, fixed value otherwise when level allows, else zero
    always_comb begin
        if (!fixedSel) begin
            allowance = st.level;
        end else if (!st.burstOpen && st.level >= `SCB_FIXED_BURST) begin
            allowance = `SCB_FIXED_BURST; // constant value
        end else begin
            allowance = 16'h0000;
        end
    end

    // level tracks bytes host may move; burst tracks fixed-mode runs
    always_comb begin
        next_st = st;
        if (phaseStart || phase == PH_NONE) begin
            next_st.level     = (phase == PH_CMD) ? `SCB_FIFO_BYTES
                                                  : 16'h0000;
            next_st.burstLeft = 16'h0000;
            next_st.burstOpen = 1'b0;
        end else begin
            // host use lowers, firmware side raises
            if (hostByte && !fwByte && st.level != 16'h0000) begin
                next_st.level = st.level - 16'h0001;
            end else if (fwByte && !hostByte &&
                         st.level != `SCB_FIFO_BYTES) begin
                next_st.level = st.level + 16'h0001;
            end
            // fixed burst opens on first host byte
            if (hostByte && !st.burstOpen) begin
                next_st.burstOpen = 1'b1;
                next_st.burstLeft = `SCB_FIXED_BURST - 16'h0001;
            end else if (hostByte && st.burstOpen) begin
                next_st.burstLeft = st.burstLeft - 16'h0001;
                if (st.burstLeft == 16'h0001) begin
                    next_st.burstOpen = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    fixed_burst_zero_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (fixedSel && st.burstOpen) |-> allowance == 16'h0000)
        else $error("fixed allowance nonzero inside a burst");
    fixed_value_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fixedSel && allowance != 16'h0000) |-> allowance == `SCB_FIXED_BURST)
        else $error("fixed allowance shows a varying value");
    // host byte alone lowers the count by one
    dyn_decrement_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        (!fixedSel && phase != PH_NONE && !phaseStart && hostByte &&
         !fwByte && st.level != 16'h0000) ##1 (!fixedSel && !phaseStart &&
         phase != PH_NONE) |-> allowance == $past(allowance) - 16'h0001)
        else $error("dynamic allowance did not decrement");
endmodule // scb_allowance
`default_nettype wire

// ==== hw/scb_status_cancel.sv ====
// Contract
// - clear strobe always reads zero
// - localities 0-2 cannot clear launch flag
// - writing zero to clear strobe ignored
// - accepted clear sets launch flag promptly
// - clear operation drops accept ready
// - clear completion raises response pending
// - abort in execution still yields response
// - finished gives normal, terminated gives aborted (code: aborted only if an abort request is pending)
// - abort resolved within long deadline
// - abort ignored outside execution
// - zero writes to abort may be ignored
// - allowance reports wait-free byte count
// - dynamic allowance follows FIFO traffic
// - fixed burst reads zero until complete
// - fixed value constant between init events
// - capability bit selects fixed or dynamic
// - clear strobe at bit 25, privileged
// - abort at bit 24, execution only
// - allowance read-only in bits 23:8
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "scb_params.svh"
module scb_status_cancel #(
    parameter logic [15:0] LONG_CYC = 16'(`SCB_LONG_CYC)
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire scb_pkg::scb_apb_req_t apbReq,
    output scb_pkg::scb_apb_rsp_t      apbRsp,
    input  wire scb_pkg::scb_fifo_ev_t fifoEv,
    input  wire logic                 launchSeq,
    output logic                      launchEstablished,
    output logic                      acceptReady,
    output logic                      responsePending,
    output logic                      abortRequest,
    output logic                      abortedResult,
    output logic [15:0]               transferAllowance
);
    import scb_pkg::*;

    localparam int FLAG_BOUND = 10;

    scb_core_t  st;
    scb_core_t  next_st;
    scb_phase_t phaseNow;
    logic [2:0]  locality;
    logic [11:0] offset;
    logic        mapped;
    logic        setup;
    logic        wrStatus;
    logic        wrCap;
    logic        privLoc;
    logic        flagExpired;
    logic        abortExpired;
    logic        hostByte;
    logic        fwByte;
    logic [31:0] rdVal;

    // locality is taken from the window the address falls in
    assign locality = apbReq.paddr[14:12];
    assign offset   = apbReq.paddr[11:0];
    assign privLoc  = (locality >= `SCB_LOC_PRIV) &&
                      (locality <= `SCB_LOC_MAX);
    assign mapped   = (apbReq.paddr[15] == 1'b0) &&
                      (locality <= `SCB_LOC_MAX) &&
                      (offset == `SCB_OFF_ACCESS ||
                       offset == `SCB_OFF_CAP ||
                       offset == `SCB_OFF_STATUS ||
                       offset == `SCB_OFF_RESULT);
    assign setup    = apbReq.psel && !apbReq.penable;
    assign wrStatus = apbReq.psel && apbReq.penable && apbReq.pwrite &&
                      mapped && offset == `SCB_OFF_STATUS;
    assign wrCap    = apbReq.psel && apbReq.penable && apbReq.pwrite &&
                      mapped && offset == `SCB_OFF_CAP;

    // zero-wait slave: access phase always completes
    assign apbRsp.pready  = apbReq.psel && apbReq.penable;
    assign apbRsp.prdata  = st.rdata;
    assign apbRsp.pslverr = st.err && apbReq.psel && apbReq.penable;

    // outward status levels
    assign launchEstablished = st.launch;
    // ready shown only in the ready state
    assign acceptReady       = (st.state == ST_READY);
    assign responsePending   = st.respPending;
    // abort held as a level toward firmware
    assign abortRequest      = st.abortReq;
    assign abortedResult     = st.aborted;

    // FIFO direction follows the life cycle
    always_comb begin
        case (st.state)
            ST_READY, ST_RECV: phaseNow = PH_CMD;
            ST_DONE:           phaseNow = PH_RESP;
            default:           phaseNow = PH_NONE;
        endcase
    end
    assign hostByte = (phaseNow == PH_CMD) ? fifoEv.hostWrByte
                                           : fifoEv.hostRdByte;
    assign fwByte   = (phaseNow == PH_CMD) ? fifoEv.fwDrainByte
                                           : fifoEv.fwFillByte;

    // count of wait-free bytes for the host
    scb_allowance u_allowance (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .phase      (phaseNow),
        .phaseStart (phaseNow != st.lastPhase),
        .fixedSel   (st.fixedSel),
        .hostByte   (hostByte),
        .fwByte     (fwByte),
        .allowance  (transferAllowance)
    );

    // length of the launch flag clear operation
    scb_cycle_timer u_flag_timer (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .run     (st.state == ST_FLAG),
        .limit   (`SCB_FLAGOP_CYC),
        .expired (flagExpired)
    );

    // deadline for an abort to resolve
    scb_cycle_timer u_abort_timer (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .run     (st.state == ST_EXEC && st.abortReq),
        .limit   (LONG_CYC),
        .expired (abortExpired)
    );

    // read data for the addressed register
    always_comb begin
        rdVal = 32'h0000_0000;
        case (offset)
            `SCB_OFF_ACCESS: rdVal[`SCB_BIT_LAUNCH] = st.launch;
            // mode select reported in capability word
            `SCB_OFF_CAP:    rdVal[`SCB_BIT_FIXSEL] = st.fixedSel;
            `SCB_OFF_STATUS: begin
                // strobe and abort bits read as zero
                rdVal[`SCB_ALW_HI:`SCB_ALW_LO] = transferAllowance;
                rdVal[`SCB_BIT_ACCRDY]         = acceptReady;
                rdVal[`SCB_BIT_RESP]           = st.respPending;
            end
            `SCB_OFF_RESULT: rdVal[`SCB_BIT_ABORTED] = st.aborted;
            default:         rdVal = 32'h0000_0000;
        endcase
        if (!mapped) begin
            rdVal = 32'h0000_0000;
        end
    end

    // life cycle, flags and bus capture
    always_comb begin
        next_st = st;
        next_st.lastPhase = phaseNow;
        if (setup) begin
            next_st.rdata = rdVal;
            next_st.err   = !mapped;
        end
        if (wrCap) begin
            next_st.fixedSel = apbReq.pwdata[`SCB_BIT_FIXSEL];
        end
        if (launchSeq) begin
            next_st.launch = 1'b0;
        end
        case (st.state)
            ST_IDLE, ST_READY: begin
                if (wrStatus && privLoc &&
                    apbReq.pwdata[`SCB_BIT_CLRSTB]) begin
                    next_st.state = ST_FLAG;
                end else if (st.state == ST_IDLE && wrStatus &&
                             apbReq.pwdata[`SCB_BIT_ACCRDY]) begin
                    next_st.state = ST_READY;
                end else if (st.state == ST_READY && fifoEv.hostWrByte) begin
                    next_st.state = ST_RECV;
                end
            end
            ST_RECV: begin
                if (wrStatus && apbReq.pwdata[`SCB_BIT_EXEC]) begin
                    next_st.state   = ST_EXEC;
                    next_st.aborted = 1'b0;
                end
            end
            ST_EXEC: begin
                // abort follows bit 24 in execution
                if (wrStatus) begin
                    next_st.abortReq = apbReq.pwdata[`SCB_BIT_ABORT];
                end
                if (fifoEv.fwCmdDone) begin
                    next_st.state       = ST_DONE;
                    next_st.respPending = 1'b1;
                    next_st.aborted     = fifoEv.fwCanceled && st.abortReq;
                end else if (abortExpired) begin
                    next_st.state       = ST_DONE;
                    next_st.respPending = 1'b1;
                    next_st.aborted     = 1'b1;
                end
            end
            ST_DONE: begin
                if (fifoEv.hostAllRead) begin
                    next_st.respPending = 1'b0;
                end
                if (wrStatus && apbReq.pwdata[`SCB_BIT_ACCRDY]) begin
                    next_st.state       = ST_READY;
                    next_st.respPending = 1'b0;
                end
            end
            ST_FLAG: begin
                if (flagExpired) begin
                    next_st.launch      = 1'b1;
                    next_st.respPending = 1'b1;
                    next_st.state       = ST_DONE;
                end
            end
            default: next_st.state = ST_IDLE;
        endcase
        if (next_st.state != ST_EXEC) begin
            next_st.abortReq = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st           <= '0;
            st.state     <= ST_IDLE;
            st.lastPhase <= PH_NONE;
            st.launch    <= `SCB_LAUNCH_RST;
            st.fixedSel  <= `SCB_FIXSEL_RST;
        end else begin
            st <= next_st;
        end
    end

    // cycles spent executing with an abort pending
    logic [15:0] abortAge;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            abortAge <= 16'h0000;
        end else if (st.state == ST_EXEC && st.abortReq) begin
            abortAge <= abortAge + 16'h0001;
        end else begin
            abortAge <= 16'h0000;
        end
    end

    sequence flag_start_s;
        wrStatus && privLoc && apbReq.pwdata[`SCB_BIT_CLRSTB] &&
        (st.state == ST_IDLE || st.state == ST_READY);
    endsequence
    sequence flag_done_s;
        st.state == ST_FLAG ##1 st.state == ST_DONE;
    endsequence

    clrstb_reads_zero_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (setup && !apbReq.pwrite &&
        offset == `SCB_OFF_STATUS) |=> !st.rdata[`SCB_BIT_CLRSTB])
        else $error("clear strobe read back nonzero");
    low_loc_ignored_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (wrStatus && !privLoc &&
        st.state != ST_FLAG) |=> st.state != ST_FLAG)
        else $error("low locality started a flag clear");
    zero_clr_ignored_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (wrStatus &&
        !apbReq.pwdata[`SCB_BIT_CLRSTB] && st.state != ST_FLAG) |=>
        st.state != ST_FLAG)
        else $error("zero write started a flag clear");
    flag_sets_launch_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) flag_start_s |-> ##[1:FLAG_BOUND]
        (st.launch && st.state == ST_DONE))
        else $error("launch flag not set in time");
    flag_not_ready_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) flag_start_s |=>
        (!acceptReady && st.state == ST_FLAG))
        else $error("accept ready kept during flag clear");
    flag_resp_pend_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) flag_done_s |-> responsePending)
        else $error("flag clear ended without response pending");
    abort_result_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (st.state == ST_EXEC && abortExpired &&
        !fifoEv.fwCmdDone) |=> (st.state == ST_DONE && abortedResult &&
        responsePending))
        else $error("abort deadline did not cancel the command");
    abort_deadline_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) abortAge <= LONG_CYC)
        else $error("abort left unresolved past the deadline");
    abort_ignored_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (wrStatus && st.state != ST_EXEC) |=>
        !abortRequest)
        else $error("abort taken outside execution");

    // abort handling and register field checks
    // abort still responds
    abort_responds_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (st.state == ST_EXEC && st.abortReq &&
        fifoEv.fwCmdDone) |=> (st.state == ST_DONE && responsePending))
        else $error("aborted command gave no response");
    finish_normal_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (st.state == ST_EXEC && fifoEv.fwCmdDone &&
        !fifoEv.fwCanceled) |=> !abortedResult)
        else $error("finished command reported as aborted");
    abort_follows_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (st.state == ST_EXEC && wrStatus &&
        !fifoEv.fwCmdDone && !abortExpired) |=>
        abortRequest == $past(apbReq.pwdata[`SCB_BIT_ABORT]))
        else $error("abort level did not follow the write");
    abort_held_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (st.state == ST_EXEC && st.abortReq &&
        !wrStatus && !fifoEv.fwCmdDone && !abortExpired) |=> abortRequest)
        else $error("abort level dropped during execution");
    alw_field_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (setup && !apbReq.pwrite && mapped &&
        offset == `SCB_OFF_STATUS) |=>
        (st.rdata[`SCB_ALW_HI:`SCB_ALW_LO] == $past(transferAllowance) &&
        !st.rdata[`SCB_BIT_ABORT]))
        else $error("status read lost the allowance field");
    cap_select_a: assert property (@(posedge ref_clk)
        disable iff (!reset_n) wrCap |=>
        st.fixedSel == $past(apbReq.pwdata[`SCB_BIT_FIXSEL]))
        else $error("allowance mode not taken from capability");
endmodule // scb_status_cancel
`default_nettype wire

// ==== bench/scb_fw_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module scb_fw_model (
    input  wire logic             ref_clk,
    output var scb_pkg::scb_fifo_ev_t fifoEv
);
    import scb_pkg::*;

    // quiet FIFO side until a task asks for traffic
    initial fifoEv = '0;

    // host bytes land in the data FIFO, one per cycle
    // exact byte count only
    task automatic hostWrite(input int n);
        repeat (n) begin
            fifoEv.hostWrByte <= 1'b1;
            @(posedge ref_clk);
        end
        fifoEv.hostWrByte <= 1'b0;
        @(posedge ref_clk);
    endtask

    // firmware ends the executing command, finished or terminated
    task automatic finish(input logic cancel);
        fifoEv.fwCmdDone  <= 1'b1;
        fifoEv.fwCanceled <= cancel;
        @(posedge ref_clk);
        fifoEv.fwCmdDone  <= 1'b0;
        fifoEv.fwCanceled <= 1'b0;
        @(posedge ref_clk);
    endtask
endmodule // scb_fw_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scb_params.svh"
module tb_top;
    import scb_pkg::*;
    localparam logic [11:0] AC = `SCB_OFF_ACCESS;
    localparam logic [11:0] CP = `SCB_OFF_CAP;
    localparam logic [11:0] ST = `SCB_OFF_STATUS;
    localparam logic [11:0] RS = `SCB_OFF_RESULT;
    logic         ref_clk;
    logic         reset_n;
    logic         launchSeq;
    logic         abortLvl;
    scb_apb_req_t req;
    scb_apb_rsp_t rsp;
    scb_fifo_ev_t ev;
    logic [31:0]  expQ[$];
    int           n_errors;
    int           samples_checked;
    int           n;

    scb_status_cancel #(.LONG_CYC(16'h0028)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .apbReq(req), .apbRsp(rsp),
        .fifoEv(ev), .launchSeq(launchSeq), .launchEstablished(),
        .acceptReady(), .responsePending(), .abortRequest(abortLvl),
        .abortedResult(), .transferAllowance());
    scb_fw_model fw (.ref_clk(ref_clk), .fifoEv(ev));

    // free-running 25 MHz clock
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    function automatic logic [15:0] ad(input int l, input logic [11:0] o);
        return {1'b0, 3'(l), o};
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t read %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is seen, then an idle cycle
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic w = 1'b1);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do @(posedge ref_clk); while (rsp.pready !== 1'b1);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        expQ.push_back(e);
        wr(a, 32'h0, 1'b0);
    endtask

    // read data compared against the oldest note at the access edge
    always @(posedge ref_clk) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1
            && expQ.size() > 0)
            check(rsp.prdata, expQ.pop_front());
    end

    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles of the tests
    initial begin
        #100000;
        n_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        stop_test();
    end

    // main sequence
    initial begin
        req = '0;
        launchSeq = 1'b0;
        reset_n = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        void'($urandom(20));
        cyc(5);
        reset_n <= 1'b1;
        cyc(1);
        rd(ad(0, AC), 32'h0000_0001);
        rd(ad(0, CP), 32'h0);
        rd(ad(0, ST), 32'h0);
        rd(16'h8000, 32'h0);
        $display("test reset done");
        launchSeq <= 1'b1;
        cyc(1);
        launchSeq <= 1'b0;
        cyc(1);
        for (int l = 0; l < 4; l++)
            wr(ad(l, ST), (l == 3) ? 32'h0 : 32'h0200_0000);
        rd(ad(0, AC), 32'h0);
        wr(ad(4, ST), 32'h0200_0000);
        rd(ad(4, ST), 32'h0);
        cyc(10);
        rd(ad(0, AC), 32'h0000_0001);
        rd(ad(4, ST), 32'h0000_0010);
        $display("test flag clear done");
        wr(ad(0, ST), 32'h40);
        rd(ad(0, ST), 32'h0000_4040);
        n = 1 + ($urandom % 8);
        fw.hostWrite(n); // at most the 64 just reported
        rd(ad(0, ST), 32'((64 - n) << 8));
        wr(ad(0, ST), 32'h20);
        wr(ad(0, ST), 32'h0100_0000);
        check({31'h0, abortLvl}, 32'h1);
        cyc(20);
        rd(ad(0, RS), 32'h0);
        cyc(30);
        rd(ad(0, RS), 32'h0000_0001);
        check({31'h0, abortLvl}, 32'h0);
        wr(ad(0, ST), 32'h40);
        wr(ad(0, ST), 32'h0100_0000);
        check({31'h0, abortLvl}, 32'h0);
        fw.hostWrite(1);
        wr(ad(0, ST), 32'h20);
        wr(ad(0, ST), 32'h0100_0000);
        wr(ad(0, ST), 32'h0);
        check({31'h0, abortLvl}, 32'h0);
        wr(ad(0, ST), 32'h0100_0000);
        fw.finish(1'b0);
        check({31'h0, abortLvl}, 32'h0);
        rd(ad(0, RS), 32'h0);
        $display("test abort done");
        wr(ad(0, CP), 32'h100);
        rd(ad(0, CP), 32'h100);
        wr(ad(0, ST), 32'h40);
        rd(ad(0, ST), 32'h0000_2040);
        fw.hostWrite(1);
        rd(ad(0, ST), 32'h0);
        fw.hostWrite(31);
        rd(ad(0, ST), 32'h0000_2000);
        $display("test fixed allowance done");
        cyc(2);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
